/* File: bench/mpsr_line_model.sv */
// Purpose: Line-side slaves seen by a mixed drop port.
// Assumes: Every slave uses the same serial settings as the port.
// Notes:   Mute models a slave that stays silent; hold keeps CTS low.
`timescale 1ns/10ps
module mpsr_line_model (
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Test controls.
    input  wire logic hold_cts_i,
    input  wire logic mute_i,
    // Line from the port.
    input  wire logic rts_i,
    input  wire logic tx_start_i,
    output logic      cts_o,
    output logic      tx_done_o,
    output logic      reply_o
);
    int frm_q; // Cycles left of the frame on the wire.
    int ans_q; // Cycles left before a slave answers.
    ////////////////////////////////////////////////////////////////////////////
    // Frame length is fixed, because all slaves share one baud rate.
    // Every slave shares the port's network identifier, so an addressed one answers.
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cts_o     <= 1'b0;
            tx_done_o <= 1'b0;
            reply_o   <= 1'b0;
            frm_q     <= 0;
            ans_q     <= 0;
        end
        else
        begin
            cts_o     <= rts_i & ~hold_cts_i;
            tx_done_o <= (frm_q == 1);
            reply_o   <= (ans_q == 1);
            frm_q     <= tx_start_i ? 4 : (frm_q > 0 ? frm_q - 1 : 0);
            // A muted slave never answers; otherwise every frame gets an answer.
            ans_q     <= (frm_q == 1 && !mute_i) ? 6 : (ans_q > 0 ? ans_q - 1 : 0);
        end
    end
endmodule : mpsr_line_model

/* File: bench/mpsr_router_tb.sv */
// Purpose: Self-checking bench for the mixed protocol serial router.
// Assumes: One millisecond is shortened to MS cycles.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/10ps
module mpsr_router_tb;
    localparam int MS = 8; // Short tick keeps the timer waits brief.
    logic clk = 0, rst = 1, dual = 0, tw = 1, bid = 0, mv = 0, hold = 0, mute = 0;
    logic [7:0] cts_dly = 8'h00, pau = 8'h00, mcnt = 8'h00, bint = 8'h00;
    logic [3:0] att = 4'h1;
    mpsr_pkg::mpsr_msg_s msg = '0;
    mpsr_pkg::mpsr_res_s res;
    logic rdy, rts, txs, oe, rxe, rv, busy, cts, txd, rep;
    logic rts_prev = 1'b0; // RTS level seen at the previous edge.
    int error_cnt = 0, n_compared = 0, n_tx = 0, n_res = 0, bad = 0, cyc = 0, t_rts = 0, t_tx = 0;
    always #4 clk = ~clk;
    mpsr_router #(.MS_CYCLES(MS)) DUT (.CLK_I(clk), .RESET_I(rst), .DUAL_MODE_I(dual),
        .TWO_WIRE_I(tw), .OWN_DROP_I(8'h35), .CTS_DELAY_I(cts_dly), .PAUSE_I(pau),
        .MSG_COUNT_I(mcnt), .REPLY_TMO_I(8'h02), .ATTEMPTS_I(att), .BID_INTERVAL_I(bint),
        .BID_REQ_I(bid), .MSG_I(msg), .MSG_VALID_I(mv), .MSG_READY_O(rdy), .CTS_I(cts),
        .TX_DONE_I(txd), .REPLY_I(rep), .RTS_O(rts), .TX_START_O(txs), .TX_OE_O(oe),
        .RX_EN_O(rxe), .RES_O(res), .RES_VALID_O(rv), .BUSY_O(busy));
    mpsr_line_model LINE (.clk_i(clk), .rst_i(rst), .hold_cts_i(hold), .mute_i(mute),
        .rts_i(rts), .tx_start_i(txs), .cts_o(cts), .tx_done_o(txd), .reply_o(rep));
    ////////////////////////////////////////////////////////////////////////////
    // Watches the line every cycle; a send without handshake is a fault.
    always @(posedge clk)
    begin
        cyc++;
        if (rv === 1'b1) n_res++;
        if (rts === 1'b1 && rts_prev !== 1'b1) t_rts = cyc;
        rts_prev = rts;
        if (txs === 1'b1)
        begin
            n_tx++;
            t_tx = cyc;
            if (!(rts && cts && oe && !rxe && busy)) bad++;
        end
        if (tw && oe && rxe) bad++;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Compares one value and counts the outcome.
    task automatic check(input logic [15:0] seen, exp, input string what);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t %s: seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check
    // Prints the counts and the verdict, then stops.
    task automatic end_sim;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim
    function automatic mpsr_pkg::mpsr_msg_s mk(input logic fl, vn, ok, input logic [3:0] ln,
                                              input logic [7:0] fd, nd, mb);
        mk = '{fl, vn, ok, ln, fd, nd, mb};
    endfunction : mk
    // Holds valid until the edge where ready was high; a hang of 100 cycles counts a mismatch.
    task automatic push(input mpsr_pkg::mpsr_msg_s m);
        logic got;
        got = 1'b0;
        msg = m;
        mv = 1'b1;
        for (int n = 0; n < 100 && !got; n++)
        begin
            got = (rdy === 1'b1);
            @(posedge clk);
            #1;
        end
        mv = 1'b0;
        check(16'(got), 16'h1, "message taken");
    endtask : push
    // Waits for one result and judges path, address and frames sent.
    task automatic wait_res(input mpsr_pkg::mpsr_path_e p, input logic [7:0] a,
                            input logic ua, input int ntx);
        for (int n = 0; n < 600 && rv !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
        end
        check(16'(rv), 16'h1, "result timeout");
        if (rv !== 1'b1) end_sim();
        check(16'(res.path), 16'(p), "path");
        if (ua) check(16'(res.addr), 16'(a), "address");
        check(16'(n_tx), 16'(ntx), "frames sent");
    endtask : wait_res
    // One message outstanding: the next is pushed only after a result.
    task automatic send(input mpsr_pkg::mpsr_msg_s m, input mpsr_pkg::mpsr_path_e p,
                        input logic [7:0] a, input logic ua, input int ntx);
        n_tx = 0;
        push(m);
        wait_res(p, a, ua, ntx);
    endtask : send
    ////////////////////////////////////////////////////////////////////////////
    // Range edges of the following drop: 0, 99, 100, 199 and 200; none is address 16.
    task automatic t_mixed;
        logic [7:0] nd [5] = '{8'h00, 8'h63, 8'h64, 8'hC7, 8'hC8};
        for (int i = 0; i < 5; i++)
            send(mk(0, 0, 1, 4'h3, 8'h35, nd[i], 8'h00),
                 i < 2 ? mpsr_pkg::P_RNP : (i < 4 ? mpsr_pkg::P_MODBUS : mpsr_pkg::P_ERROR),
                 nd[i] - 8'h64, i inside {[2:3]}, i < 4 ? 1 : 0);
        send(mk(1, 0, 1, 4'h0, 8'h00, 8'h00, 8'h05), mpsr_pkg::P_REFUSE, 0, 0, 0);
        $display("mixed drop routing done");
    endtask : t_mixed
    // Silent slaves: one Modbus try only, network packets use all attempts.
    task automatic t_retry;
        mute = 1'b1;
        att = 4'h3;
        send(mk(0, 0, 1, 4'h3, 8'h35, 8'h7D, 8'h00), mpsr_pkg::P_NOREPLY, 0, 0, 1);
        send(mk(0, 0, 1, 4'h3, 8'h35, 8'h13, 8'h00), mpsr_pkg::P_ERROR, 0, 0, 3);
        mute = 1'b0;
        att = 4'h1;
        $display("retry handling done");
    endtask : t_retry
    // The same CTS delay holds back both protocols.
    task automatic t_cts;
        cts_dly = 8'h02;
        send(mk(0, 0, 1, 4'h3, 8'h35, 8'h13, 8'h00), mpsr_pkg::P_RNP, 0, 0, 1);
        check(16'(t_tx - t_rts >= MS && t_tx - t_rts <= 4 * MS), 16'h1, "delay");
        send(mk(0, 0, 1, 4'h3, 8'h35, 8'h7D, 8'h00), mpsr_pkg::P_MODBUS, 8'h19, 1, 1);
        check(16'(t_tx - t_rts >= MS && t_tx - t_rts <= 4 * MS), 16'h1, "delay");
        cts_dly = 8'h00;
        n_tx = 0;
        bid = 1'b1;
        @(posedge clk);
        #1;
        bid = 1'b0;
        wait_res(mpsr_pkg::P_BID, 0, 0, 1);
        $display("handshake and bid done");
    endtask : t_cts
    // Two sends of either protocol use up the shared count, then the port pauses.
    task automatic t_pause;
        int n;
        n = 0;
        mcnt = 8'h02;
        pau = 8'h03;
        send(mk(0, 0, 1, 4'h3, 8'h35, 8'h13, 8'h00), mpsr_pkg::P_RNP, 0, 0, 1);
        check(16'(busy), 16'h0, "no pause yet");
        send(mk(0, 0, 1, 4'h3, 8'h35, 8'h7D, 8'h00), mpsr_pkg::P_MODBUS, 8'h19, 1, 1);
        while (busy === 1'b1 && n < 100)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check(16'(n >= 2 * MS && n <= 4 * MS), 16'h1, "pause length");
        mcnt = 8'h00;
        pau = 8'h00;
        n_tx = 0;
        bint = 8'h04;
        wait_res(mpsr_pkg::P_BID, 0, 0, 1);
        bint = 8'h00;
        $display("pause and automatic bid done");
    endtask : t_pause
    // Dual slave: vendor and Modbus frames decided, nothing sent on the line.
    // The master starts every exchange; no Modbus address is 16 or 254.
    task automatic t_dual;
        dual = 1'b1;
        send(mk(1, 1, 1, 4'h0, 8'h00, 8'h00, 8'h00), mpsr_pkg::P_LOCAL, 0, 0, 0);
        send(mk(1, 1, 1, 4'h2, 8'h35, 8'h05, 8'h00), mpsr_pkg::P_FWD, 0, 0, 0);
        send(mk(1, 1, 1, 4'h2, 8'hC9, 8'h05, 8'h00), mpsr_pkg::P_FWD, 0, 0, 0);
        send(mk(1, 1, 1, 4'h2, 8'h07, 8'h05, 8'h00), mpsr_pkg::P_ERROR, 0, 0, 0);
        send(mk(1, 0, 1, 4'h0, 8'h00, 8'h00, 8'hFF), mpsr_pkg::P_LOCAL, 0, 0, 0);
        send(mk(1, 0, 1, 4'h0, 8'h00, 8'h00, 8'h05), mpsr_pkg::P_MBTAB, 0, 0, 0);
        send(mk(1, 1, 0, 4'h2, 8'h35, 8'h05, 8'h00), mpsr_pkg::P_DISCARD, 0, 0, 0);
        dual = 1'b0;
        $display("dual slave done");
    endtask : t_dual
    // Fills the queue while CTS is withheld, then drains it completely.
    task automatic t_fill;
        int acc;
        acc = 0;
        hold = 1'b1;
        n_res = 0;
        msg = mk(0, 0, 1, 4'h3, 8'h35, 8'h13, 8'h00);
        mv = 1'b1;
        while (rdy === 1'b1 && acc < 40)
        begin
            @(posedge clk);
            #1;
            acc++;
        end
        mv = 1'b0;
        check(16'(rdy), 16'h0, "full queue refuses");
        check(16'(acc >= 32), 16'h1, "queue depth");
        hold = 1'b0;
        for (int n = 0; n < 3000 && n_res < acc; n++)
        begin
            @(posedge clk);
            #1;
        end
        check(16'(n_res), 16'(acc), "all drained");
        check(16'(bad), 16'h0, "line faults");
        $display("queue fill done");
    endtask : t_fill
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        check(16'({busy, rdy, rxe, rv, rts, txs, oe}), 16'h0030, "reset outputs");
        t_mixed();
        t_retry();
        t_cts();
        t_pause();
        t_dual();
        t_fill();
        end_sim();
    end
endmodule : mpsr_router_tb

/* File: src/mpsr_cfg.svh */
// Purpose: Named constants for the mixed protocol serial router.
// Assumes: 125 MHz core clock; timers count in millisecond ticks.
// Notes:   Definitions only; included by the package and the router.
`ifndef MPSR_CFG_SVH
`define MPSR_CFG_SVH
`define MPSR_CLK_NS      8
`define MPSR_MS_NS       1000000
`define MPSR_RNP_MAX     8'h63
`define MPSR_MB_MAX      8'hC7
`define MPSR_MB_OFS      8'h64
`define MPSR_WILD_DROP   8'hC9
`define MPSR_MB_LOCAL    8'hFF
`define MPSR_FIFO_DEPTH  32
`define MPSR_ST_IDLE     3'h0
`define MPSR_ST_RTS      3'h1
`define MPSR_ST_SEND     3'h3
`define MPSR_ST_WAIT     3'h2
`define MPSR_ST_PAUSE    3'h6
`endif

/* File: src/mpsr_fifo.sv */
// Purpose: Message FIFO with valid/ready on both sides.
// Assumes: Single clock; depth is a power of two.
// Notes:   Ready and valid come straight from flops.
`timescale 1ns/10ps
module mpsr_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    // Clock and reset.
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Fill side.
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    // Drain side.
    output logic [W-1:0]      out_data_o,
    output logic              out_valid_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(D);
    // Pointer and flag state.
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
        logic          room;
        logic          avail;
    } mpsr_fifo_s;
    mpsr_fifo_s   s_q;   // Registered state.
    mpsr_fifo_s   s_d;   // Next state.
    logic [W-1:0] mem [D]; // Storage words.
    logic         wr;    // Write this cycle.
    logic         rd;    // Read this cycle.

    assign wr = in_valid_i & s_q.room;
    assign rd = out_ready_i & s_q.avail;
    assign in_ready_o  = s_q.room;
    assign out_valid_o = s_q.avail;
    assign out_data_o  = mem[s_q.rp];

    // Next pointers; flags are precomputed so the ports stay registered.
    always_comb
    begin
        s_d = s_q;
        if (wr) s_d.wp = s_q.wp + 1'b1;
        if (rd) s_d.rp = s_q.rp + 1'b1;
        s_d.cnt   = s_q.cnt + (AW+1)'(wr) - (AW+1)'(rd);
        s_d.room  = s_d.cnt != (AW+1)'(D);
        s_d.avail = s_d.cnt != '0;
    end

    // State and storage registers.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i) begin
            s_q <= '{wp: '0, rp: '0, cnt: '0, room: 1'b1, avail: 1'b0};
        end else begin
            s_q <= s_d;
            if (wr) mem[s_q.wp] <= in_data_i;
        end
    end
endmodule : mpsr_fifo

/* File: src/mpsr_pkg.sv */
// Purpose: Types shared by the router and its bench.
// Assumes: Constants come from mpsr_cfg.svh.
// Notes:   Holds types only.
`include "mpsr_cfg.svh"
package mpsr_pkg;
    // Controller states, Gray coded along idle, rts, send, wait, pause.
    typedef enum logic [2:0] {
        ST_IDLE  = `MPSR_ST_IDLE,
        ST_RTS   = `MPSR_ST_RTS,
        ST_SEND  = `MPSR_ST_SEND,
        ST_WAIT  = `MPSR_ST_WAIT,
        ST_PAUSE = `MPSR_ST_PAUSE
    } mpsr_state_e;
    // What was done with a message.
    typedef enum logic [3:0] {
        P_NONE, P_RNP, P_MODBUS, P_BID, P_LOCAL, P_FWD,
        P_MBTAB, P_ERROR, P_NOREPLY, P_REFUSE, P_DISCARD
    } mpsr_path_e;
    // Message descriptor entering the router.
    typedef struct packed {
        logic       from_line;  // Arrived on the serial line as a slave.
        logic       vendor;     // Framing looks like vendor protocol.
        logic       chk_ok;     // Check field was good.
        logic [3:0] route_len;  // Number of drops in the route.
        logic [7:0] first_drop; // First route drop.
        logic [7:0] next_drop;  // Drop after this port's own drop.
        logic [7:0] mb_addr;    // Modbus slave address of the frame.
    } mpsr_msg_s;
    // Dispatch result.
    typedef struct packed {
        mpsr_path_e path;
        logic [7:0] addr;
    } mpsr_res_s;
endpackage : mpsr_pkg

/* File: src/mpsr_router.sv */
// Purpose: Message dispatcher for one serial port in mixed drop or dual slave mode.
// Assumes: Serial framing, CRC and the routing table live outside.
// Notes:   Timers count millisecond ticks of a prescaler.
// Function
// - Next drop 0..99 goes as network packet.
// - Next drop 100..199 goes Modbus, address minus 100.
// - Mixed drop port refuses incoming slave messages.
// - One CTS timer, pause, count for both.
// - Modbus never retried; network packets use retries.
// - Manual and automatic bid polling as usual.
// - Dual slave accepts vendor and Modbus frames.
// - Every vendor message with a good check gets data or error reply.
// - Vendor route starts own drop or 201.
// - Empty vendor route accesses local registers.
// - Modbus via routing table; 255 is local.
// - Raise RTS, wait delay and CTS, send.
// - Two-wire: driver off unless sending, receiver off while sending.
`timescale 1ns/10ps
`include "mpsr_cfg.svh"
module mpsr_router #(
    parameter int MS_CYCLES = `MPSR_MS_NS / `MPSR_CLK_NS
) (
    // Clock and reset.
    input  wire logic               CLK_I,
    input  wire logic               RESET_I,
    // Configuration.
    input  wire logic               DUAL_MODE_I,
    input  wire logic               TWO_WIRE_I,
    input  wire logic [7:0]         OWN_DROP_I,
    input  wire logic [7:0]         CTS_DELAY_I,
    input  wire logic [7:0]         PAUSE_I,
    input  wire logic [7:0]         MSG_COUNT_I,
    input  wire logic [7:0]         REPLY_TMO_I,
    input  wire logic [3:0]         ATTEMPTS_I,
    input  wire logic [7:0]         BID_INTERVAL_I,
    input  wire logic               BID_REQ_I,
    // Message input.
    input  wire mpsr_pkg::mpsr_msg_s MSG_I,
    input  wire logic               MSG_VALID_I,
    output logic                    MSG_READY_O,
    // Line control.
    input  wire logic               CTS_I,
    input  wire logic               TX_DONE_I,
    input  wire logic               REPLY_I,
    output logic                    RTS_O,
    output logic                    TX_START_O,
    output logic                    TX_OE_O,
    output logic                    RX_EN_O,
    // Results.
    output mpsr_pkg::mpsr_res_s     RES_O,
    output logic                    RES_VALID_O,
    output logic                    BUSY_O
);
    ////////////////////////////////////////////////////////////////////////////
    // Whole state of the block in one struct.
    typedef struct packed {
        mpsr_pkg::mpsr_state_e st;
        mpsr_pkg::mpsr_res_s   res;     // Current or last result.
        logic                  res_v;   // Result pulse.
        logic                  rnp;     // Current send may retry.
        logic [3:0]            tries;   // Retries used so far.
        logic [16:0]           pre;     // Millisecond prescaler.
        logic [7:0]            tmr;     // Millisecond timer.
        logic [7:0]            sent;    // Messages since last pause.
        logic [7:0]            bid_cnt; // Milliseconds since last automatic bid request.
        logic                  bid_pend;
        logic [2:0]            cts_s;   // CTS synchroniser chain.
        logic                  cts;     // Filtered CTS level.
        logic                  rts;
        logic                  tx_start;
        logic                  txoe;
        logic                  rxen;
        logic                  busy;    // Registered busy level.
    } mpsr_rt_s;
    mpsr_rt_s            s_q;    // Registered state.
    mpsr_rt_s            s_d;    // Next state.
    mpsr_pkg::mpsr_msg_s f_msg;  // FIFO head.
    logic                f_valid; // FIFO head valid.
    logic                pop;    // Controller can take a message.
    logic                tick;   // One-millisecond strobe.
    mpsr_pkg::mpsr_res_s dec;    // Decision for the FIFO head.
    logic                f_room; // FIFO can accept.

    ////////////////////////////////////////////////////////////////////////////
    // Routing decision for one message.
    function automatic mpsr_pkg::mpsr_res_s route(input mpsr_pkg::mpsr_msg_s m,
                                                  input logic dual,
                                                  input logic [7:0] own);
        mpsr_pkg::mpsr_res_s r;
        r = '{path: mpsr_pkg::P_ERROR, addr: m.next_drop};
        if (dual) begin
            // Corrupt frames are dropped before any path is chosen.
            if (!m.chk_ok) r.path = mpsr_pkg::P_DISCARD;
            else if (m.vendor) begin
                r.addr = m.first_drop;
                if (m.route_len == 4'h0) r.path = mpsr_pkg::P_LOCAL;
                else if (m.first_drop == own || m.first_drop == `MPSR_WILD_DROP)
                    r.path = mpsr_pkg::P_FWD;
                else r.path = mpsr_pkg::P_ERROR;
            end else begin
                r.addr = m.mb_addr;
                r.path = (m.mb_addr == `MPSR_MB_LOCAL) ? mpsr_pkg::P_LOCAL
                                                        : mpsr_pkg::P_MBTAB;
            end
        end else if (m.from_line) begin
            r.path = mpsr_pkg::P_REFUSE;
        end else if (m.next_drop <= `MPSR_RNP_MAX) begin
            r.path = mpsr_pkg::P_RNP;
        end else if (m.next_drop <= `MPSR_MB_MAX) begin
            r.path = mpsr_pkg::P_MODBUS;
            r.addr = m.next_drop - `MPSR_MB_OFS;
        end
        // Anything left over keeps the error reply.
        return r;
    endfunction : route

    ////////////////////////////////////////////////////////////////////////////
    // Incoming messages wait here so the upstream source is stalled honestly.
    mpsr_fifo #(.W($bits(mpsr_pkg::mpsr_msg_s)), .D(`MPSR_FIFO_DEPTH)) u_fifo (
        .clk_i       (CLK_I),
        .rst_i       (RESET_I),
        .in_data_i   (MSG_I),
        .in_valid_i  (MSG_VALID_I),
        .in_ready_o  (f_room),
        .out_data_o  (f_msg),
        .out_valid_o (f_valid),
        .out_ready_i (pop)
    );

    // Pending bids go first; in dual mode no bid is ever originated.
    assign pop  = (s_q.st == mpsr_pkg::ST_IDLE) && !(s_q.bid_pend && !DUAL_MODE_I);
    assign tick = s_q.pre == 17'(MS_CYCLES - 1);
    assign dec  = route(f_msg, DUAL_MODE_I, OWN_DROP_I);

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic for the whole controller.
    always_comb
    begin
        s_d = s_q;
        s_d.res_v = 1'b0;
        s_d.tx_start = 1'b0;
        s_d.pre = tick ? 17'h0 : s_q.pre + 17'h1;
        if (tick && s_q.tmr != 8'hFF) s_d.tmr = s_q.tmr + 8'h1;
        // Only the second and third stages are compared; the first is a bare flop.
        s_d.cts_s = {s_q.cts_s[1:0], CTS_I};
        if (s_q.cts_s[2] == s_q.cts_s[1]) s_d.cts = s_q.cts_s[2];
        case (s_q.st)
            mpsr_pkg::ST_IDLE:
            begin
                if (s_q.bid_pend && !DUAL_MODE_I) begin
                    // Bids behave like ordinary network polls, retries included.
                    s_d.bid_pend = 1'b0;
                    s_d.res = '{path: mpsr_pkg::P_BID, addr: 8'h0};
                    s_d.rnp = 1'b1;
                    s_d.tries = 4'h0;
                    s_d.st = mpsr_pkg::ST_RTS;
                    s_d.rts = 1'b1;
                    s_d.tmr = 8'h0;
                end else if (f_valid) begin
                    s_d.res = dec;
                    s_d.rnp = dec.path != mpsr_pkg::P_MODBUS;
                    s_d.tries = 4'h0;
                    if (dec.path == mpsr_pkg::P_RNP || dec.path == mpsr_pkg::P_MODBUS)
                    begin
                        s_d.st = mpsr_pkg::ST_RTS;
                        s_d.rts = 1'b1;
                        s_d.tmr = 8'h0;
                    end else begin
                        s_d.res_v = 1'b1;
                    end
                end
            end
            mpsr_pkg::ST_RTS:
            begin
                // One shared CTS delay for both protocols; zero waits only for CTS.
                if (s_q.tmr >= CTS_DELAY_I && s_q.cts) begin
                    s_d.st = mpsr_pkg::ST_SEND;
                    s_d.tx_start = 1'b1;
                end
            end
            mpsr_pkg::ST_SEND:
            begin
                if (TX_DONE_I) begin
                    s_d.st = mpsr_pkg::ST_WAIT;
                    s_d.rts = 1'b0;
                    s_d.tmr = 8'h0;
                end
            end
            mpsr_pkg::ST_WAIT:
            begin
                if (REPLY_I || s_q.tmr >= REPLY_TMO_I) begin
                    if (!REPLY_I && s_q.rnp && (s_q.tries + 4'h1) < ATTEMPTS_I) begin
                        s_d.tries = s_q.tries + 4'h1;
                        s_d.st = mpsr_pkg::ST_RTS;
                        s_d.rts = 1'b1;
                        s_d.tmr = 8'h0;
                    end else begin
                        // Modbus falls straight through here with no retry.
                        if (!REPLY_I)
                            s_d.res.path = s_q.rnp ? mpsr_pkg::P_ERROR
                                                   : mpsr_pkg::P_NOREPLY;
                        s_d.res_v = 1'b1;
                        s_d.sent = s_q.sent + 8'h1;
                        s_d.st = mpsr_pkg::ST_IDLE;
                        if (MSG_COUNT_I != 8'h0 && s_q.sent + 8'h1 >= MSG_COUNT_I) begin
                            s_d.sent = 8'h0;
                            s_d.st = mpsr_pkg::ST_PAUSE;
                            s_d.tmr = 8'h0;
                        end
                    end
                end
            end
            mpsr_pkg::ST_PAUSE:
            begin
                if (s_q.tmr >= PAUSE_I) s_d.st = mpsr_pkg::ST_IDLE;
            end
            default:
            begin
                s_d.st = mpsr_pkg::ST_IDLE;
                s_d.rts = 1'b0;
            end
        endcase
        // A disabled count starts afresh, so enabling it never pauses at once.
        if (MSG_COUNT_I == 8'h0) s_d.sent = 8'h0;
        // Automatic bid timer; placed last so a new request beats the clear.
        if (!DUAL_MODE_I && BID_INTERVAL_I != 8'h0 && tick) begin
            s_d.bid_cnt = s_q.bid_cnt + 8'h1;
            if (s_q.bid_cnt + 8'h1 >= BID_INTERVAL_I) begin
                s_d.bid_cnt = 8'h0;
                s_d.bid_pend = 1'b1;
            end
        end
        if (BID_REQ_I && !DUAL_MODE_I) s_d.bid_pend = 1'b1;
        // In two-wire operation the driver follows the send state only.
        s_d.txoe = !TWO_WIRE_I || s_d.st == mpsr_pkg::ST_SEND;
        s_d.rxen = !(TWO_WIRE_I && s_d.st == mpsr_pkg::ST_SEND);
        // Busy is registered so the output comes straight from a flop.
        s_d.busy = s_d.st != mpsr_pkg::ST_IDLE;
    end

    // State register; reset loads constants only.
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I) s_q <= '{st: mpsr_pkg::ST_IDLE, res: '{mpsr_pkg::P_NONE, 8'h0},
                              rxen: 1'b1, default: '0};
        else s_q <= s_d;
    end

    assign MSG_READY_O = f_room;
    assign RTS_O       = s_q.rts;
    assign TX_START_O  = s_q.tx_start;
    assign TX_OE_O     = s_q.txoe;
    assign RX_EN_O     = s_q.rxen;
    assign RES_O       = s_q.res;
    assign RES_VALID_O = s_q.res_v;
    assign BUSY_O      = s_q.busy;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on routing and line control.
    a_rnp_range: assert property (@(posedge CLK_I) disable iff (RESET_I)
        pop && f_valid && !DUAL_MODE_I && !f_msg.from_line && f_msg.next_drop <= `MPSR_RNP_MAX
        |=> RTS_O && RES_O.path == mpsr_pkg::P_RNP) else $error("drop 0..99 not sent as packet");
    a_mb_addr: assert property (@(posedge CLK_I) disable iff (RESET_I)
        pop && f_valid && !DUAL_MODE_I && !f_msg.from_line
            && f_msg.next_drop > `MPSR_RNP_MAX && f_msg.next_drop <= `MPSR_MB_MAX
        |=> RES_O.path == mpsr_pkg::P_MODBUS
            && RES_O.addr == $past(f_msg.next_drop) - `MPSR_MB_OFS)
        else $error("bad modbus address");
    a_refuse_slave: assert property (@(posedge CLK_I) disable iff (RESET_I)
        pop && f_valid && !DUAL_MODE_I && f_msg.from_line
        |=> RES_VALID_O && !RTS_O && RES_O.path == mpsr_pkg::P_REFUSE)
        else $error("slave message taken");
    a_cts_gate: assert property (@(posedge CLK_I) disable iff (RESET_I)
        $rose(TX_START_O) |-> $past(s_q.cts) && RTS_O) else $error("sent without cts");
    a_rx_off: assert property (@(posedge CLK_I) disable iff (RESET_I)
        TWO_WIRE_I && $past(TWO_WIRE_I) && !RX_EN_O |-> TX_OE_O)
        else $error("receiver off while idle");
    a_no_mb_retry: assert property (@(posedge CLK_I) disable iff (RESET_I)
        s_q.st == mpsr_pkg::ST_WAIT && !s_q.rnp && !REPLY_I && s_q.tmr >= REPLY_TMO_I
        |=> RES_VALID_O && !RTS_O) else $error("modbus retried");
    a_local_empty: assert property (@(posedge CLK_I) disable iff (RESET_I)
        pop && f_valid && DUAL_MODE_I && f_msg.chk_ok && f_msg.vendor && f_msg.route_len == 4'h0
        |=> RES_VALID_O && RES_O.path == mpsr_pkg::P_LOCAL) else $error("empty route not local");
    a_err_range: assert property (@(posedge CLK_I) disable iff (RESET_I)
        pop && f_valid && !DUAL_MODE_I && !f_msg.from_line && f_msg.next_drop > `MPSR_MB_MAX
        |=> RES_VALID_O && RES_O.path == mpsr_pkg::P_ERROR)
        else $error("out of range not refused");
    a_local_255: assert property (@(posedge CLK_I) disable iff (RESET_I)
        pop && f_valid && DUAL_MODE_I && f_msg.chk_ok && !f_msg.vendor && f_msg.mb_addr == 8'hFF
        |=> RES_O.path == mpsr_pkg::P_LOCAL) else $error("address 255 not local");
endmodule : mpsr_router
